// [hw/frfc_cfg.svh]
/*
  Constants for the floating-point register format codec: field positions,
  encodings, exponent limits and real-type properties.
  Assumes it is included once per compilation unit; the guard handles repeats.
*/
`ifndef FRFC_CFG_SVH
`define FRFC_CFG_SVH

// Field layout of the 82-bit register
`define FRFC_REG_W 82
`define FRFC_EXP_W 17
`define FRFC_SIG_W 64
`define FRFC_TEXP_W 18

// Exponent encodings
`define FRFC_EXP_ONES 17'h1ffff
`define FRFC_EXP_ZERO 17'h00000
`define FRFC_EXP_BIAS 18'h0ffff
`define FRFC_EXP_INT 17'h1003e
`define FRFC_EXP_ONE 17'h0ffff

// True exponent for a zero exponent field, -16382
`define FRFC_TEXP_DENORM 18'h3c002

// Exponent limits per real type (two's complement, 18 bits)
`define FRFC_EMAX_SGL 18'h0007f
`define FRFC_EMIN_SGL 18'h3ff82
`define FRFC_EMAX_DBL 18'h003ff
`define FRFC_EMIN_DBL 18'h3fc02
`define FRFC_EMAX_EXT 18'h03fff
`define FRFC_EMIN_EXT 18'h3c002

// Precision and stored width per real type
`define FRFC_PREC_SGL 7'h18
`define FRFC_PREC_DBL 7'h35
`define FRFC_PREC_EXT 7'h40
`define FRFC_STORE_SGL 7'h20
`define FRFC_STORE_DBL 7'h40
`define FRFC_STORE_EXT 7'h50

// Constant register contents: index 0 is +0.0, index 1 is +1.0
`define FRFC_IDX_W 7
`define FRFC_IDX_ZERO 7'h00
`define FRFC_IDX_ONE 7'h01
`define FRFC_SIG_ONE 64'h8000000000000000

`endif

// [hw/frfc_pkg.sv]
/*
  Types for the floating-point register format codec.
  Assumes frfc_cfg.svh is on the include path.
*/
`include "frfc_cfg.svh"

package frfc_pkg;

  // One register split into its three fields
  typedef struct packed {
    logic sign;
    logic [`FRFC_EXP_W-1:0] exp;
    logic [`FRFC_SIG_W-1:0] sig;
  } frfc_reg_s;

  // One-hot class of a register value
  typedef struct packed {
    logic is_int;
    logic is_nan;
    logic is_inf;
    logic is_normal;
    logic is_denorm;
    logic is_zero;
  } frfc_class_s;

  typedef enum logic [1:0] {
    FRFC_TYPE_SGL = 2'b00,
    FRFC_TYPE_DBL = 2'b01,
    FRFC_TYPE_EXT = 2'b10
  } frfc_type_e;

  typedef enum logic {
    FRFC_PC_EXT_RANGE = 1'b0,
    FRFC_PC_DEST_PREC = 1'b1
  } frfc_pc_e;

endpackage : frfc_pkg

// [hw/frfc_codec.sv]
/*
  Register-format codec: substitutes the two constant registers on a read,
  classifies the value, derives its true exponent, splits paired singles and
  checks the exponent against the range chosen by precision control.
  Assumes a read port of the floating-point register file on the same clock;
  all outputs are registered, so results appear one edge after the inputs.
*/
`include "frfc_cfg.svh"
module frfc_codec
  import frfc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [`FRFC_IDX_W-1:0] i_rd_idx,
  input wire frfc_reg_s i_rd_data,
  input wire frfc_type_e i_dest_type,
  input wire frfc_pc_e i_pc_mode,
  output frfc_reg_s o_rd_data,
  output frfc_class_s o_class,
  output logic o_negative,
  output logic [`FRFC_TEXP_W-1:0] o_true_exp,
  output logic o_in_range,
  output logic [6:0] o_prec_bits,
  output logic [6:0] o_store_bits,
  output logic [31:0] o_ps_hi,
  output logic [31:0] o_ps_lo,
  output logic [63:0] o_int_value,
  output logic o_ps_bad
);

  // Constant registers override whatever the file returns
  frfc_reg_s const_one;
  frfc_reg_s val;
  assign const_one = '{sign: 1'b0, exp: `FRFC_EXP_ONE, sig: `FRFC_SIG_ONE};
  assign val = (i_rd_idx == `FRFC_IDX_ZERO) ? '0 :
               (i_rd_idx == `FRFC_IDX_ONE) ? const_one : i_rd_data;

  // Field decode
  wire logic exp_ones = (val.exp == `FRFC_EXP_ONES);
  wire logic exp_zero = (val.exp == `FRFC_EXP_ZERO);
  wire logic sig_zero = (val.sig == '0);
  wire logic frac_zero = (val.sig[62:0] == '0);
  wire logic canon_int = (val.exp == `FRFC_EXP_INT) && !val.sign;

  // Class, one-hot; canonical integer shape wins over plain finite
  frfc_class_s cls;
  assign cls.is_zero = exp_zero && sig_zero;
  assign cls.is_denorm = exp_zero && !sig_zero;
  assign cls.is_inf = exp_ones && frac_zero;
  assign cls.is_nan = exp_ones && !frac_zero;
  assign cls.is_int = canon_int;
  assign cls.is_normal = !exp_zero && !exp_ones && !canon_int;

  // True exponent: biased for nonzero fields, fixed minimum for zero field
  logic [`FRFC_TEXP_W-1:0] biased_exp;
  logic [`FRFC_TEXP_W-1:0] true_exp;
  assign biased_exp = {1'b0, val.exp} - `FRFC_EXP_BIAS;
  assign true_exp = exp_zero ? `FRFC_TEXP_DENORM : biased_exp;

  // Exponent window picked by precision control and destination type
  logic [`FRFC_TEXP_W-1:0] emax;
  logic [`FRFC_TEXP_W-1:0] emin;
  logic [6:0] prec_bits;
  logic [6:0] store_bits;
  wire logic use_ext = (i_pc_mode == FRFC_PC_EXT_RANGE);
  wire logic dest_sgl = (i_dest_type == FRFC_TYPE_SGL);
  wire logic dest_dbl = (i_dest_type == FRFC_TYPE_DBL);
  // Extended-range mode ignores the destination for emax and emin only; an unused type code reads as extended
  assign emax = use_ext ? `FRFC_EMAX_EXT :
                dest_sgl ? `FRFC_EMAX_SGL :
                dest_dbl ? `FRFC_EMAX_DBL : `FRFC_EMAX_EXT;
  assign emin = use_ext ? `FRFC_EMIN_EXT :
                dest_sgl ? `FRFC_EMIN_SGL :
                dest_dbl ? `FRFC_EMIN_DBL : `FRFC_EMIN_EXT;
  assign prec_bits = dest_sgl ? `FRFC_PREC_SGL :
                     dest_dbl ? `FRFC_PREC_DBL : `FRFC_PREC_EXT;
  assign store_bits = dest_sgl ? `FRFC_STORE_SGL :
                      dest_dbl ? `FRFC_STORE_DBL : `FRFC_STORE_EXT;

  // Only finite nonzero values can fall outside the window
  // Limitation: the raw exponent is compared, unnormals are not normalised first
  wire logic finite_nz = cls.is_normal || cls.is_denorm;
  wire logic below_max = ($signed(true_exp) <= $signed(emax));
  wire logic above_min = ($signed(true_exp) >= $signed(emin));
  wire logic in_range = !finite_nz || (below_max && above_min);

  // Paired singles need the canonical exponent and a clear sign
  wire logic ps_bad = (val.exp != `FRFC_EXP_INT) || val.sign;

  // Paired-single halves: entry 0 is the low single, entry 1 the high one
  logic [31:0] ps_half [2];
  for (genvar g = 0; g < 2; g++) begin : g_ps_half
    assign ps_half[g] = val.sig[32*g +: 32];
  end

  // Every output is its own short register stage
  // One cycle of latency keeps timing off the register file read path,
  // traded against one extra pipeline slot for the consumer

  // Value after constant substitution
  // Zero and one never leak whatever the file holds
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= val;
    end
  end

  // One-hot class
  // All zero only while reset holds, so checkers can spot a stale class
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_class <= '0;
    end else begin
      o_class <= cls;
    end
  end

  // Sign bit
  // Kept apart so paired-single users can test it alone
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_negative <= 1'b0;
    end else begin
      o_negative <= val.sign;
    end
  end

  // True exponent
  // Two's complement, so negative exponents need no extra flag
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_true_exp <= '0;
    end else begin
      o_true_exp <= true_exp;
    end
  end

  // Range verdict
  // Forced high for non-finite classes, which have no window
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_in_range <= 1'b0;
    end else begin
      o_in_range <= in_range;
    end
  end

  // Precision of the destination type
  // Follows the type even in extended-range mode
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_prec_bits <= '0;
    end else begin
      o_prec_bits <= prec_bits;
    end
  end

  // Stored width of the destination type
  // Memory side uses this to size its transfer
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_store_bits <= '0;
    end else begin
      o_store_bits <= store_bits;
    end
  end

  // High paired single
  // Passed through even when the shape is not canonical
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_ps_hi <= '0;
    end else begin
      o_ps_hi <= ps_half[1];
    end
  end

  // Low paired single
  // Same stage as the high half, so both stay aligned
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_ps_lo <= '0;
    end else begin
      o_ps_lo <= ps_half[0];
    end
  end

  // Integer view of the significand
  // Signedness is left to the consumer
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_int_value <= '0;
    end else begin
      o_int_value <= val.sig;
    end
  end

  // Paired-single shape error
  // Flags rather than repairs, the consumer decides what to do
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_ps_bad <= 1'b0;
    end else begin
      o_ps_bad <= ps_bad;
    end
  end

endmodule : frfc_codec

// [dv/frfc_regfile_model.sv]
/* Register file model feeding the codec read port.
   Assumes the bench writes an entry before reading it. */
module frfc_regfile_model
  import frfc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_wr_en,
  input wire logic [6:0] i_wr_idx,
  input wire frfc_reg_s i_wr_data,
  input wire logic [6:0] i_rd_idx,
  output frfc_reg_s o_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  frfc_reg_s mem_q [128];
  // Unwritten entries stay unknown, so stale reads show up
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en) mem_q[i_wr_idx] <= i_wr_data;
  end
  assign o_rd_data = mem_q[i_rd_idx];
endmodule : frfc_regfile_model

// [dv/frfc_codec_assertions.sv]
/* Port checks for the codec, one cycle from input to output.
   Assumes bound to frfc_codec. */
module frfc_codec_assertions
  import frfc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [6:0] i_rd_idx,
  input wire frfc_reg_s i_rd_data,
  input wire frfc_reg_s o_rd_data,
  input wire frfc_class_s o_class,
  input wire logic o_negative,
  input wire logic [17:0] o_true_exp,
  input wire logic [31:0] o_ps_hi,
  input wire logic [31:0] o_ps_lo,
  input wire logic o_ps_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  wire logic [16:0] e = i_rd_data.exp;
  wire logic [63:0] s = i_rd_data.sig;
  // Reset gone a full cycle, so the first edge after release is not judged
  sequence s_up; !i_reset && !$past(i_reset); endsequence
  sequence s_take; s_up ##0 i_rd_idx > 7'h01; endsequence
  AST_ONEHOT: assert property (s_up |=> $onehot(o_class)) else $error("class");
  AST_ZERO: assert property (s_take ##0 e == 17'h0 && s == 64'h0 |=> o_class.is_zero)
    else $error("zero");
  AST_INF: assert property (s_take ##0 &e && s[62:0] == 63'h0 |=> o_class.is_inf)
    else $error("inf");
  AST_NAN: assert property (s_take ##0 &e && s[62:0] != 63'h0 |=> o_class.is_nan)
    else $error("nan");
  AST_DEN: assert property (s_take ##0 e == 17'h0 && s != 64'h0 |=> o_class.is_denorm)
    else $error("denorm");
  AST_TEXP: assert property (s_take ##0 e != 17'h0 |=>
    o_true_exp == {1'b0, $past(e)} - 18'h0ffff) else $error("exp");
  AST_NEG: assert property (s_take |=> o_negative == $past(i_rd_data.sign))
    else $error("sign");
  AST_PS: assert property (s_take |=> {o_ps_hi, o_ps_lo} == $past(s)) else $error("ps");
  AST_INT: assert property (s_take ##0 e == 17'h1003e && !i_rd_data.sign |=>
    o_class.is_int && !o_ps_bad) else $error("int");
  AST_ONE: assert property (s_up ##0 i_rd_idx == 7'h01 |=>
    o_rd_data == {1'b0, 17'h0ffff, 64'h8000000000000000}) else $error("one");
endmodule : frfc_codec_assertions
bind frfc_codec frfc_codec_assertions u_chk (.i_ref_clk, .i_reset, .i_rd_idx, .i_rd_data,
  .o_rd_data, .o_class, .o_negative, .o_true_exp, .o_ps_hi, .o_ps_lo, .o_ps_bad);

// [dv/frfc_codec_bench.sv]
/* Self-checking bench: model register file in front of the codec.
   Assumes registered outputs one edge after the inputs. */
module frfc_codec_bench
  import frfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic wr_en = 1'b0;
  logic [6:0] idx = 7'h00;
  frfc_reg_s wr_data = '0;
  logic [6:0] rd_idx = 7'h00;
  frfc_type_e dt = FRFC_TYPE_EXT;
  frfc_pc_e pc = FRFC_PC_EXT_RANGE;
  frfc_reg_s rd_data, q_data;
  frfc_class_s q_cls;
  logic q_neg, q_rng, q_bad;
  logic [17:0] q_exp;
  logic [6:0] q_prec, q_st;
  logic [31:0] q_hi, q_lo;
  logic [63:0] q_int;
  int n_mismatch = 0;
  int comparisons = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  frfc_regfile_model u_rf (.i_ref_clk, .i_wr_en(wr_en), .i_wr_idx(idx), .i_wr_data(wr_data),
    .i_rd_idx(rd_idx), .o_rd_data(rd_data));
  frfc_codec DUT (.i_ref_clk, .i_reset, .i_rd_idx(rd_idx), .i_rd_data(rd_data),
    .i_dest_type(dt), .i_pc_mode(pc), .o_rd_data(q_data), .o_class(q_cls), .o_negative(q_neg),
    .o_true_exp(q_exp), .o_in_range(q_rng), .o_prec_bits(q_prec), .o_store_bits(q_st),
    .o_ps_hi(q_hi), .o_ps_lo(q_lo), .o_int_value(q_int), .o_ps_bad(q_bad));
  task automatic chk(input logic [81:0] got, input logic [81:0] want);
    comparisons++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, want);
    end
  endtask : chk
  // Write one entry, then read it through the codec with type and mode
  task automatic run(input logic [6:0] i, input frfc_reg_s v,
      input frfc_type_e t = FRFC_TYPE_EXT, input frfc_pc_e m = FRFC_PC_EXT_RANGE);
    @(posedge i_ref_clk);
    wr_en <= 1'b1;
    idx <= i;
    wr_data <= v;
    @(posedge i_ref_clk);
    wr_en <= 1'b0;
    rd_idx <= i;
    dt <= t;
    pc <= m;
    @(posedge i_ref_clk);
    #1;
  endtask : run
  task automatic t_special;
    run(7'h02, '{1'b1, 17'h0, 64'h0});
    chk({q_cls, q_neg}, {6'h01, 1'b1});
    run(7'h03, '{1'b0, 17'h1ffff, 64'h8000000000000000});
    chk(q_cls, 6'h08);
    run(7'h04, '{1'b0, 17'h1ffff, 64'h0000000000000001});
    chk(q_cls, 6'h10);
    run(7'h05, '{1'b0, 17'h0, 64'h8000000000000000});
    chk({q_cls, q_exp}, {6'h02, 18'h3c002});
    run(7'h06, '{1'b0, 17'h0fffe, 64'h8000000000000000});
    chk({q_cls, q_exp}, {6'h04, 18'h3ffff});
  endtask : t_special
  // Canonical integer, then the integer exponent with the sign set and a zero significand
  task automatic t_int;
    run(7'h07, '{1'b0, 17'h1003e, 64'h0123456789abcdef});
    chk({q_cls, q_bad, q_hi, q_lo}, {6'h20, 1'b0, 64'h0123456789abcdef});
    chk(q_int, 64'h0123456789abcdef);
    run(7'h08, '{1'b1, 17'h1003e, 64'h0});
    chk(q_bad, 1'b1);
  endtask : t_int
  // Junk stored at 0 and 1 must never reach the output
  task automatic t_const;
    run(7'h00, '{1'b1, 17'h1ffff, 64'h5});
    chk(q_data, 82'h0);
    chk(q_cls, 6'h01);
    run(7'h01, '{1'b1, 17'h00123, 64'h7});
    chk(q_data, {1'b0, 17'h0ffff, 64'h8000000000000000});
  endtask : t_const
  // Widths for single and double, then true exponent 200 under both modes
  task automatic t_types;
    run(7'h09, '{1'b0, 17'h0ffff, 64'h8000000000000000}, FRFC_TYPE_SGL);
    chk({q_prec, q_st}, {7'h18, 7'h20});
    run(7'h09, '{1'b0, 17'h0ffff, 64'h8000000000000000}, FRFC_TYPE_DBL);
    chk({q_prec, q_st}, {7'h35, 7'h40});
    run(7'h0a, '{1'b0, 17'h100c7, 64'h8000000000000000}, FRFC_TYPE_SGL, FRFC_PC_DEST_PREC);
    chk({q_prec, q_st, q_rng}, {7'h18, 7'h20, 1'b0});
    run(7'h0a, '{1'b0, 17'h100c7, 64'h8000000000000000}, FRFC_TYPE_SGL);
    chk(q_rng, 1'b1);
  endtask : t_types
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    t_special();
    t_int();
    t_const();
    t_types();
    summarize();
  end
  // Whole run is under 100 cycles
  initial begin
    #10000;
    n_mismatch++;
    summarize();
  end
endmodule : frfc_codec_bench
